// *** rtl/clu_top.sv ***
// instruction interpreter: parallel and i2c byte ports, command execution, rams
module clu_top import clu_pkg::*; #(
    parameter int unsigned BLINK_HALF = BLINK_HALF_CYC
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire clu_pin_s pin_i,
    output logic [7:0] db_o,
    output logic db_oe_o,
    input wire clu_i2c_s i2c_i,
    output logic [7:0] i2c_rd_o,
    input wire logic [6:0] disp_addr_i,
    output logic [7:0] disp_code_o,
    output clu_disp_s disp_o
);
    localparam int unsigned BW = $clog2(BLINK_HALF + 1);

    typedef struct packed {
        logic [TEXT_N-1:0][7:0] text;
        logic [GLYPH_N-1:0][4:0] glyph;
        logic [6:0] addr;
        logic glyph_sel;
        logic [7:0] dlatch;
        logic [7:0] busy_cnt;
        logic step_up;
        logic auto_pan;
        logic pic_on;
        logic curs_on;
        logic flash_on;
        logic bus_width;
        logic pump_hi;
        logic [1:0] lines;
        logic [6:0] shift;
        logic [BW-1:0] blink_cnt;
        logic blink_ph;
        logic e_q;
        logic nib;
        logic [3:0] nib_hi;
        logic [7:0] db;
        logic db_oe;
        logic ctrl_exp;
        logic more_ctrl;
        logic i2c_rs;
        logic i2c_rw;
        logic [7:0] i2c_rd;
        logic [7:0] disp_code;
    } clu_st_s;

    clu_st_s st_r;
    clu_st_s st_nxt;
    clu_pin_s ps;

    logic busy;
    logic e_rise;
    logic e_fall;
    logic [7:0] p_rd;
    logic [7:0] i_rd;
    logic x_vld;
    logic x_rs;
    logic x_rw;
    logic x_i2c;
    logic [7:0] x_b;
    logic go;
    logic [2:0] hi;
    logic [6:0] new_a;

    // pins come from the host's domain, so they are resampled first
    clu_sync #(.W(PORT_W)) u_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .d_i(pin_i),
        .q_o(ps)
    );

    always_comb begin
        st_nxt = st_r;
        busy = st_r.busy_cnt != 8'h00;
        p_rd = ps.reg_pick ? st_r.dlatch : {busy, st_r.addr};
        i_rd = st_r.i2c_rs ? st_r.dlatch : {busy, st_r.addr};
        e_rise = 1'b0;
        e_fall = 1'b0;
        x_vld = 1'b0;
        x_rs = 1'b0;
        x_rw = 1'b0;
        x_i2c = 1'b0;
        x_b = 8'h00;
        go = 1'b0;
        hi = 3'h0;
        new_a = st_r.addr;
        for (int i = 0; i < 8; i++) begin
            if (st_r.busy_cnt == 8'h00 && x_b[i]) hi = 3'(i);
        end
        if (ce_i) begin
            e_rise = ps.e & ~st_r.e_q;
            e_fall = ~ps.e & st_r.e_q;
            st_nxt.e_q = ps.e;
            st_nxt.disp_code = st_r.text[disp_addr_i];
            // parallel port: read drive on rise, transfer completes on fall
            if (e_rise && ps.rw) begin
                st_nxt.db_oe = 1'b1;
                st_nxt.db = (!st_r.bus_width && st_r.nib) ? {p_rd[3:0], 4'h0} : p_rd;
            end
            if (e_fall) begin
                st_nxt.db_oe = 1'b0;
                if (st_r.bus_width || st_r.nib) begin
                    x_vld = 1'b1;
                    x_rs = ps.reg_pick;
                    x_rw = ps.rw;
                    x_b = st_r.bus_width ? ps.db : {st_r.nib_hi, ps.db[7:4]};
                    st_nxt.nib = 1'b0;
                end else begin
                    st_nxt.nib = 1'b1;
                    st_nxt.nib_hi = ps.db[7:4];
                end
            end
            // i2c byte stream; the parallel port wins a same-cycle clash
            if (i2c_i.start) begin
                st_nxt.ctrl_exp = 1'b1;
            end else if (i2c_i.wr_vld) begin
                if (st_r.ctrl_exp) begin
                    st_nxt.more_ctrl = i2c_i.data[CTL_MORE];
                    st_nxt.i2c_rs = i2c_i.data[CTL_RS];
                    st_nxt.i2c_rw = i2c_i.data[CTL_RW];
                    st_nxt.ctrl_exp = 1'b0;
                end else begin
                    st_nxt.ctrl_exp = st_r.more_ctrl;
                    if (!x_vld) begin
                        x_vld = 1'b1;
                        x_i2c = 1'b1;
                        x_rs = st_r.i2c_rs;
                        x_b = i2c_i.data;
                    end
                end
            end else if (i2c_i.rd_req) begin
                st_nxt.i2c_rd = i_rd;
                if (!x_vld) begin
                    x_vld = 1'b1;
                    x_i2c = 1'b1;
                    x_rs = st_r.i2c_rs;
                    x_rw = 1'b1;
                end
            end
            hi = 3'h0;
            for (int i = 0; i < 8; i++) begin
                if (x_b[i]) hi = 3'(i);
            end
            // status reads pass even while busy; anything else then is dropped
            go = x_vld && (x_rs || !x_rw) && !busy;
            if (go) begin
                st_nxt.busy_cnt = 8'(EXEC_CYC);
                if (!x_rs && x_b == 8'h00) begin
                    st_nxt.busy_cnt = 8'h00;
                end else if (!x_rs) begin
                    case (hi)
                        CMD_CLR: begin
                            st_nxt.text = {TEXT_N{SPACE_CODE}};
                            st_nxt.addr = 7'h00;
                            st_nxt.shift = 7'h00;
                            st_nxt.step_up = 1'b1;
                            st_nxt.glyph_sel = 1'b0;
                            st_nxt.busy_cnt = 8'(CLR_CYC);
                        end
                        CMD_HOME: begin
                            st_nxt.addr = 7'h00;
                            st_nxt.shift = 7'h00;
                            st_nxt.glyph_sel = 1'b0;
                        end
                        CMD_ENTRY: begin
                            st_nxt.step_up = x_b[1];
                            st_nxt.auto_pan = x_b[0];
                        end
                        CMD_DISP: begin
                            st_nxt.pic_on = x_b[2];
                            st_nxt.curs_on = x_b[1];
                            st_nxt.flash_on = x_b[0];
                        end
                        CMD_SHIFT: begin
                            if (x_b[SH_SC]) begin
                                st_nxt.shift = clu_pan(st_r.shift, ~x_b[SH_RL], st_r.lines);
                            end else begin
                                st_nxt.addr = clu_step(st_r.addr, x_b[SH_RL], st_r.lines);
                            end
                        end
                        CMD_FUNC: begin
                            if (!x_i2c) begin
                                st_nxt.bus_width = x_b[FS_DL];
                            end
                            if ({x_b[FS_M], x_b[FS_N]} != LINES_RSV) begin
                                st_nxt.lines = {x_b[FS_M], x_b[FS_N]};
                            end
                            st_nxt.pump_hi = x_b[FS_G];
                            st_nxt.nib = 1'b0;
                        end
                        CMD_GLYPH: begin
                            st_nxt.addr = {st_r.addr[6], x_b[5:0]};
                            st_nxt.glyph_sel = 1'b1;
                            st_nxt.dlatch = {3'h0, st_r.glyph[x_b[5:0]]};
                        end
                        default: begin
                            st_nxt.addr = x_b[6:0];
                            st_nxt.glyph_sel = 1'b0;
                            st_nxt.dlatch = st_r.text[x_b[6:0]];
                        end
                    endcase
                end else begin
                    // plain +/-1 in glyph space, layout wrap in text space
                    new_a = st_r.glyph_sel
                        ? (st_r.step_up ? st_r.addr + 7'h01 : st_r.addr - 7'h01)
                        : clu_step(st_r.addr, st_r.step_up, st_r.lines);
                    st_nxt.addr = new_a;
                    if (!x_rw) begin
                        if (st_r.glyph_sel) begin
                            st_nxt.glyph[st_r.addr[5:0]] = x_b[4:0];
                        end else begin
                            st_nxt.text[st_r.addr] = x_b;
                            if (st_r.auto_pan) begin
                                st_nxt.shift = clu_pan(st_r.shift, st_r.step_up, st_r.lines);
                            end
                        end
                    end else begin
                        st_nxt.dlatch = st_r.glyph_sel ? {3'h0, st_r.glyph[new_a[5:0]]}
                                                       : st_r.text[new_a];
                    end
                end
            end else if (busy) begin
                st_nxt.busy_cnt = st_r.busy_cnt - 8'h01;
            end
            // flash phase; counted in oscillator cycles so it scales with rate
            if (st_r.flash_on) begin
                if (st_r.blink_cnt == BW'(BLINK_HALF - 1)) begin
                    st_nxt.blink_cnt = '0;
                    st_nxt.blink_ph = ~st_r.blink_ph;
                end else begin
                    st_nxt.blink_cnt = st_r.blink_cnt + BW'(1);
                end
            end else begin
                st_nxt.blink_cnt = '0;
                st_nxt.blink_ph = 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
            st_r.text <= {TEXT_N{SPACE_CODE}};
            st_r.bus_width <= RST_BUS_WIDTH;
            st_r.step_up <= RST_STEP_UP;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign db_o = st_r.db;
    assign db_oe_o = st_r.db_oe;
    assign i2c_rd_o = st_r.i2c_rd;
    assign disp_code_o = st_r.disp_code;

    always_comb begin
        disp_o.busy_flag = busy;
        disp_o.addr_ptr = st_r.addr;
        disp_o.glyph_sel = st_r.glyph_sel;
        disp_o.pic_on = st_r.pic_on;
        disp_o.curs_on = st_r.curs_on & ~st_r.glyph_sel;
        disp_o.flash_on = st_r.flash_on & ~st_r.glyph_sel;
        disp_o.flash_ph = st_r.blink_ph;
        disp_o.lines = st_r.lines;
        disp_o.pump_hi = st_r.pump_hi;
        disp_o.bus_width = st_r.bus_width;
        disp_o.shift = st_r.shift;
    end

    // checks
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    logic cmd_go;
    assign cmd_go = go && !x_rs && x_b != 8'h00;

    clr_busy_a: assert property (cmd_go && hi == CMD_CLR |=> st_r.busy_cnt == 8'd165)
        else $error("clear did not load 165 busy cycles");
    exec_busy_a: assert property (cmd_go && hi != CMD_CLR |=> busy ##2 busy ##1 !busy)
        else $error("command busy time is not 3 cycles");
    drop_busy_a: assert property (ce_i && x_vld && busy |=> $stable(st_r.addr))
        else $error("instruction executed while busy");
    stat_read_a: assert property (ce_i && i2c_i.rd_req && !st_r.i2c_rs && !i2c_i.start
        |=> i2c_rd_o == {$past(busy), $past(st_r.addr)})
        else $error("status byte wrong");
    clear_eff_a: assert property (cmd_go && hi == CMD_CLR |=> st_r.text[0] == 8'h20
        && st_r.addr == 7'h00 && st_r.shift == 7'h00 && st_r.step_up)
        else $error("clear effects missing");
    home_eff_a: assert property (cmd_go && hi == CMD_HOME |=> st_r.addr == 7'h00
        && st_r.shift == 7'h00 && $stable(st_r.step_up) && $stable(st_r.auto_pan))
        else $error("home effects wrong");
    i2c_width_a: assert property (cmd_go && x_i2c && hi == CMD_FUNC
        |=> $stable(st_r.bus_width))
        else $error("i2c changed bus width");
    glyph_addr_a: assert property (cmd_go && hi == CMD_GLYPH |=> st_r.glyph_sel
        && st_r.addr[6] == $past(st_r.addr[6]) && !disp_o.curs_on)
        else $error("glyph address load wrong");
    glyph_step_a: assert property (go && x_rs && st_r.glyph_sel && st_r.step_up
        |=> st_r.addr == $past(st_r.addr) + 7'h01)
        else $error("glyph pointer did not step");
    busy_down_a: assert property (ce_i && busy |=> st_r.busy_cnt == $past(st_r.busy_cnt) - 8'h01)
        else $error("busy counter not counting down");

    clear_c: cover property (cmd_go && hi == CMD_CLR);
    glyph_wr_c: cover property (go && x_rs && !x_rw && st_r.glyph_sel);
    nibble_c: cover property (e_fall && !st_r.bus_width && st_r.nib);
    i2c_data_c: cover property (go && x_i2c && x_rs);
endmodule : clu_top

// *** include/clu_pkg.sv ***
// constants, carriers and helpers of the character display instruction unit
// How it works
// - reset gives 8-bit width, one line, low pump, all display bits off, step up
// - while busy only the status read is served, everything else dropped
// - command byte decoded by its highest set bit; zero byte does nothing
// - busy lasts 165 cycles after clear, 3 after others, none for nop/status
// - status read gives busy on bit 7 and pointer on bits 6..0
// - data access goes to the memory picked by the last address command
// - i2c control byte carries more_ctrl, reg_pick, direction, five zeros
// - more_ctrl low: only data follows; high: one data byte then control
// - function set over i2c ignores the width bit, stays 8-bit
// - clear fills text_ram with 20h, zeroes pointer and shift, steps up
// - home zeroes pointer and shift, keeps text, step and pan
// - data access steps pointer by one; cursor hidden on glyph_ram
// - auto-pan shifts display on text writes only, direction from step
// - picture bit blanks without touching text; underline cursor shown
// - flashing alternates cursor cell with all dots, 150000 cycle period
// - shift command moves cursor with pointer or display without it
// - cursor runs onto next line; display shift wraps within each line
// - width bit picks whole bytes or two nibbles on upper data lines
// - line bits pick one, two or four-line layout; code 10 reserved
// - glyph address loads bits 5..0 only; text address loads all 7
// - after data read, pointer steps and data_latch prefetches new byte
// - text write pointer wraps at line ends per layout
// - in 4-bit mode upper nibble goes first, status read too
// - glyph_ram keeps only the five low data bits
package clu_pkg;
    localparam int unsigned CLR_CYC = 165;
    localparam int unsigned EXEC_CYC = 3;
    localparam int unsigned BLINK_REF_KHZ = 150;
    localparam int unsigned BLINK_PERIOD_MS = 1000;
    localparam int unsigned BLINK_HALF_CYC = BLINK_REF_KHZ * BLINK_PERIOD_MS / 2;
    localparam int unsigned TEXT_N = 128;
    localparam int unsigned GLYPH_N = 64;
    localparam int unsigned PORT_W = 11;
    localparam logic [7:0] SPACE_CODE = 8'h20;
    localparam logic [6:0] END_1L = 7'h4f;
    localparam logic [5:0] END_2L = 6'h27;
    localparam logic [4:0] END_4L = 5'h13;
    localparam logic [6:0] LEN_1L = 7'h50;
    localparam logic [6:0] LEN_2L = 7'h28;
    localparam logic [6:0] LEN_4L = 7'h14;
    localparam logic [1:0] LINES_1 = 2'h0;
    localparam logic [1:0] LINES_2 = 2'h1;
    localparam logic [1:0] LINES_RSV = 2'h2;
    localparam logic RST_BUS_WIDTH = 1'b1;
    localparam logic RST_STEP_UP = 1'b1;
    localparam logic [2:0] CMD_CLR = 3'h0;
    localparam logic [2:0] CMD_HOME = 3'h1;
    localparam logic [2:0] CMD_ENTRY = 3'h2;
    localparam logic [2:0] CMD_DISP = 3'h3;
    localparam logic [2:0] CMD_SHIFT = 3'h4;
    localparam logic [2:0] CMD_FUNC = 3'h5;
    localparam logic [2:0] CMD_GLYPH = 3'h6;
    localparam logic [2:0] CMD_TEXT = 3'h7;
    localparam int unsigned FS_DL = 4;
    localparam int unsigned FS_N = 3;
    localparam int unsigned FS_M = 2;
    localparam int unsigned FS_G = 1;
    localparam int unsigned SH_SC = 3;
    localparam int unsigned SH_RL = 2;
    localparam int unsigned CTL_MORE = 7;
    localparam int unsigned CTL_RS = 6;
    localparam int unsigned CTL_RW = 5;

    typedef struct packed {
        logic e;
        logic reg_pick;
        logic rw;
        logic [7:0] db;
    } clu_pin_s;

    typedef struct packed {
        logic start;
        logic wr_vld;
        logic rd_req;
        logic [7:0] data;
    } clu_i2c_s;

    typedef struct packed {
        logic busy_flag;
        logic [6:0] addr_ptr;
        logic glyph_sel;
        logic pic_on;
        logic curs_on;
        logic flash_on;
        logic flash_ph;
        logic [1:0] lines;
        logic pump_hi;
        logic bus_width;
        logic [6:0] shift;
    } clu_disp_s;

    // pointer step with line-end wrap of the active layout
    function automatic logic [6:0] clu_step(input logic [6:0] a, input logic up,
                                            input logic [1:0] ln);
        logic [6:0] r;
        r = up ? a + 7'h01 : a - 7'h01;
        if (ln == LINES_1) begin
            if (up && a == END_1L) r = 7'h00;
            if (!up && a == 7'h00) r = END_1L;
        end else if (ln == LINES_2) begin
            if (up && a[5:0] == END_2L) r = {~a[6], 6'h00};
            if (!up && a[5:0] == 6'h00) r = {~a[6], END_2L};
        end else begin
            if (up && a[4:0] == END_4L) r = {a[6:5] + 2'h1, 5'h00};
            if (!up && a[4:0] == 5'h00) r = {a[6:5] - 2'h1, END_4L};
        end
        return r;
    endfunction : clu_step

    // display offset, modulo one line length so lines never mix
    function automatic logic [6:0] clu_pan(input logic [6:0] s, input logic left,
                                           input logic [1:0] ln);
        logic [6:0] len;
        len = (ln == LINES_1) ? LEN_1L : (ln == LINES_2) ? LEN_2L : LEN_4L;
        if (left) return (s >= len - 7'h01) ? 7'h00 : s + 7'h01;
        return (s == 7'h00 || s >= len) ? len - 7'h01 : s - 7'h01;
    endfunction : clu_pan
endpackage : clu_pkg

// *** rtl/clu_sync.sv ***
// two-flop synchroniser for the parallel port pins
module clu_sync #(
    parameter int unsigned W = 11
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } clu_sync_s;

    clu_sync_s st_r;
    clu_sync_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (ce_i) begin
            st_nxt.s1 = d_i;
            st_nxt.s2 = st_r.s1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q_o = st_r.s2;
endmodule : clu_sync

// *** sim/clu_host.sv ***
// host model: drives the parallel pins at the strobe rate and reads back
module clu_host import clu_pkg::*; (
    input wire logic clock_i,
    input wire logic [7:0] db_i,
    input wire logic db_oe_i,
    output clu_pin_s pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic e_r = 1'b0;
    logic rs_r = 1'b0;
    logic rw_r = 1'b0;
    logic drv_r = 1'b0;
    logic [7:0] wd_r = 8'h00;
    logic [7:0] last_r = 8'h00;
    // released lines toggle so a stale value can never read as an answer
    assign pin_o = '{e: e_r, reg_pick: rs_r, rw: rw_r,
                     db: db_oe_i ? db_i : (drv_r ? wd_r : ~last_r)};
    always @(posedge clock_i) last_r <= pin_o.db;
    // 4 cycles high, 4 low: data held well past the fall for the synchroniser
    task automatic strobe(input logic rs, input logic rw, input logic [7:0] d,
                          output logic [7:0] q);
        @(negedge clock_i);
        rs_r = rs;
        rw_r = rw;
        wd_r = d;
        drv_r = !rw;
        e_r = 1'b1;
        repeat (4) @(negedge clock_i);
        q = pin_o.db;
        e_r = 1'b0;
        repeat (4) @(negedge clock_i);
        drv_r = 1'b0;
    endtask : strobe
    // low nibble lines float high in 4-bit mode
    task automatic xfer(input logic nib, input logic rs, input logic rw,
                        input logic [7:0] d, output logic [7:0] q);
        logic [7:0] hi;
        logic [7:0] lo;
        if (!nib) begin
            strobe(rs, rw, d, q);
        end else begin
            strobe(rs, rw, {d[7:4], 4'hf}, hi);
            strobe(rs, rw, {d[3:0], 4'hf}, lo);
            q = {hi[7:4], lo[7:4]};
        end
    endtask : xfer
endmodule : clu_host

// *** sim/clu_top_tb.sv ***
// self-checking bench: parallel host model plus an i2c byte driver
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module clu_top_tb import clu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    clu_i2c_s i2c = '0;
    logic [6:0] da = 7'h00;
    clu_pin_s pin;
    logic [7:0] db, i2c_rd, code, q;
    logic db_oe;
    clu_disp_s d;
    int fail_count = 0;
    int n_compared = 0;
    int run = 0;
    int last_run = 0;
    clu_top #(.BLINK_HALF(8)) uut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .ce_i(1'b1), .pin_i(pin), .db_o(db), .db_oe_o(db_oe), .i2c_i(i2c),
        .i2c_rd_o(i2c_rd), .disp_addr_i(da), .disp_code_o(code), .disp_o(d));
    clu_host host (.clock_i(clock_i), .db_i(db), .db_oe_i(db_oe), .pin_o(pin));
    initial forever #12.5 clock_i = ~clock_i;
    // length of the latest busy stretch, counted in clock cycles
    always @(negedge clock_i) begin
        if (d.busy_flag === 1'b1) run++;
        else if (run != 0) begin
            last_run = run;
            run = 0;
        end
    end
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    task automatic idle();
        int n;
        n = 0;
        while (d.busy_flag !== 1'b0 && n < 400) begin
            @(negedge clock_i);
            n++;
        end
        // one more edge so the busy-run counter has settled before anyone reads it
        @(negedge clock_i);
        `CHK(n < 400, 1'b1)
    endtask : idle
    task automatic cmd(input logic [7:0] c);
        idle();
        host.xfer(!d.bus_width, 1'b0, 1'b0, c, q);
    endtask : cmd
    task automatic wr(input logic [7:0] c);
        idle();
        host.xfer(!d.bus_width, 1'b1, 1'b0, c, q);
    endtask : wr
    task automatic rd(input logic rs);
        idle();
        host.xfer(!d.bus_width, rs, 1'b1, 8'h00, q);
    endtask : rd
    task automatic peek(input logic [6:0] a, input logic [7:0] e);
        @(negedge clock_i);
        da = a;
        repeat (2) @(negedge clock_i);
        `CHK(code, e)
    endtask : peek
    task automatic iput(input logic s, input logic w, input logic r, input logic [7:0] v);
        @(negedge clock_i);
        i2c = '{start: s, wr_vld: w, rd_req: r, data: v};
        @(negedge clock_i);
        i2c = '0;
    endtask : iput
    task automatic t_reset();
        `CHK({d.bus_width, d.lines, d.pump_hi, d.pic_on, d.curs_on, d.flash_on}, 7'h40)
        `CHK({d.busy_flag, d.addr_ptr, d.shift}, 15'h0000)
    endtask : t_reset
    task automatic t_text();
        logic p;
        cmd(8'h85);
        `CHK(d.addr_ptr, 7'h05)
        idle();
        `CHK(last_run, 3)
        wr(8'h41);
        `CHK(d.addr_ptr, 7'h06)
        peek(7'h05, 8'h41);
        cmd(8'h0f);
        `CHK({d.pic_on, d.curs_on, d.flash_on}, 3'h7)
        p = d.flash_ph;
        repeat (8) @(negedge clock_i);
        `CHK(d.flash_ph, ~p)
        cmd(8'h04);
        wr(8'h42);
        `CHK(d.addr_ptr, 7'h05)
        cmd(8'h07);
        wr(8'h43);
        `CHK({d.addr_ptr, d.shift}, {7'h06, 7'h01})
        rd(1'b0);
        `CHK(q, 8'h06)
        cmd(8'h02);
        `CHK({d.addr_ptr, d.shift}, 14'h0000)
        peek(7'h05, 8'h43);
    endtask : t_text
    task automatic t_glyph();
        cmd(8'hc5);
        cmd(8'h43);
        `CHK({d.glyph_sel, d.addr_ptr, d.curs_on}, 9'h186)
        wr(8'hff);
        `CHK({d.addr_ptr, d.shift}, {7'h44, 7'h00})
        cmd(8'h43);
        rd(1'b1);
        `CHK(q, 8'h1f)
        `CHK(d.addr_ptr, 7'h44)
    endtask : t_glyph
    task automatic t_clear();
        cmd(8'h05);
        cmd(8'h01);
        host.xfer(1'b0, 1'b0, 1'b0, 8'h85, q);
        host.xfer(1'b0, 1'b0, 1'b1, 8'h00, q);
        `CHK(q, 8'h80)
        idle();
        `CHK(last_run, 165)
        `CHK({d.glyph_sel, d.addr_ptr, d.shift}, 15'h0000)
        peek(7'h05, 8'h20);
        wr(8'h31);
        `CHK({d.addr_ptr, d.shift}, {7'h01, 7'h01})
    endtask : t_clear
    task automatic t_func();
        cmd(8'h06);
        cmd(8'h3e);
        `CHK({d.lines, d.pump_hi, d.bus_width}, 4'hf)
        cmd(8'h28);
        `CHK({d.lines, d.pump_hi, d.bus_width}, 4'h4)
        cmd(8'h92);
        rd(1'b0);
        `CHK(q, 8'h12)
        cmd(8'h30);
        rd(1'b0);
        `CHK({d.bus_width, q}, 9'h112)
        cmd(8'hcf);
        wr(8'h55);
        `CHK(d.addr_ptr, 7'h00)
        cmd(8'h02);
        cmd(8'h14);
        cmd(8'h1c);
        `CHK({d.addr_ptr, d.shift}, {7'h01, 7'h4f})
        cmd(8'h38);
        cmd(8'ha7);
        wr(8'h56);
        `CHK(d.addr_ptr, 7'h40)
    endtask : t_func
    task automatic t_i2c();
        iput(1'b1, 1'b0, 1'b0, 8'h00);
        iput(1'b0, 1'b1, 1'b0, 8'h80);
        iput(1'b0, 1'b1, 1'b0, 8'h2c);
        idle();
        `CHK({d.lines, d.bus_width}, 3'h7)
        iput(1'b0, 1'b1, 1'b0, 8'h40);
        iput(1'b0, 1'b1, 1'b0, 8'h61);
        idle();
        iput(1'b0, 1'b1, 1'b0, 8'h62);
        idle();
        peek(7'h40, 8'h61);
        peek(7'h41, 8'h62);
        iput(1'b1, 1'b0, 1'b0, 8'h00);
        iput(1'b0, 1'b1, 1'b0, 8'h00);
        iput(1'b0, 1'b0, 1'b1, 8'h00);
        `CHK(i2c_rd, 8'h42)
    endtask : t_i2c
    initial begin
        repeat (2) @(negedge clock_i);
        rst_n_i = 1'b1;
        t_reset();
        t_text();
        t_glyph();
        t_clear();
        t_func();
        t_i2c();
        report_and_stop();
    end
    // whole run is some 15 us; eight times that means a hang
    initial begin
        #120us;
        fail_count++;
        report_and_stop();
    end
endmodule : clu_top_tb
